// *** core/mq_read_port_cfg.svh ***
// Purpose: constants for the multi-queue read port and flag bus block
// Assumes: included by bare name
// Notes: byte offsets of the control/status registers on the register bus
`ifndef MQ_READ_PORT_CFG_SVH
`define MQ_READ_PORT_CFG_SVH
`define MQ_DATA_W 40
`define MQ_QUEUES 32
`define MQ_QUADS 4
`define MQ_FLAG_W 8
`define MQ_OFF_CTRL 8'h00
`define MQ_OFF_STAT 8'h04
`define MQ_OFF_QSTAT 8'h08
`define MQ_CTRL_PLL_BIT 0
`define MQ_CTRL_MIRROR_BIT 1
`define MQ_CTRL_MIRROR_LSB 2
`define MQ_CTRL_RESET 32'h0000_0000
`define MQ_AXI_OKAY 2'b00
`define MQ_AXI_SLVERR 2'b10
`endif

// *** core/mq_read_port_pkg.sv ***
// Purpose: types shared by the read port design
// Assumes: nothing
// Notes: polled quadrant sequence is Gray coded
package mq_read_port_pkg;
  typedef enum logic [1:0] {
    QUAD0 = 2'b00,
    QUAD1 = 2'b01,
    QUAD2 = 2'b11,
    QUAD3 = 2'b10
  } quad_e;
  typedef logic [39:0] word_t;
endpackage

// *** core/queue_mem_if.sv ***
// Purpose: carrier between the read port and its queue memory
// Assumes: one read per cycle
// Notes: data returns one clock after the address
`timescale 1ns/1ps
`default_nettype none
interface queue_mem_if;
  logic [4:0] rdAddr; // queue index to read
  logic rdEn; // read strobe
  logic [39:0] rdData; // registered read data
  logic [4:0] wrAddr; // queue index to write
  logic wrEn; // write strobe
  logic [39:0] wrData; // write data
  modport port (output rdAddr, output rdEn, input rdData,
                output wrAddr, output wrEn, output wrData);
  modport mem (input rdAddr, input rdEn, output rdData,
               input wrAddr, input wrEn, input wrData);
endinterface
`default_nettype wire

// *** core/queue_head_mem.sv ***
// Purpose: head word store, one word per queue
// Assumes: single clock
// Notes: read data come out of a register
`timescale 1ns/1ps
`default_nettype none
`include "mq_read_port_cfg.svh"
module queue_head_mem (
  // clock
  input wire logic clk,
  // memory port
  queue_mem_if.mem mp
);
  logic [39:0] store [0:`MQ_QUEUES-1]; // head words
  logic [39:0] rdData_r; // registered output

  // write then registered read
  always_ff @(posedge clk) begin
    if (mp.wrEn) begin
      store[mp.wrAddr] <= mp.wrData;
    end
    if (mp.rdEn) begin
      rdData_r <= store[mp.rdAddr];
    end
  end

  assign mp.rdData = rdData_r;
endmodule // queue_head_mem
`default_nettype wire

// *** core/multiqueue_read_port_flag_bus.sv ***
// Purpose: read port, flag pins and flag status buses of a multi-queue buffer
// Assumes: one clock stands for both read and write clocks; pins synced twice
// Notes: three-state pins are split into value and enable
`timescale 1ns/1ps
`default_nettype none
`include "mq_read_port_cfg.svh"
// Functional notes
// - master drives data while enable low
// - slave floats data until selected
// - almost-empty pin follows selected read queue
// - empty status bus eight queues per quadrant
// - empty bus in direct or polled mode
// - empty status bus can float
// - direct mode quadrant picked by strobe, address
// - polled mode steps quadrants, sync pulse
// - almost-full pin follows selected write queue
// - full status bus eight bits, floatable
// - full quadrant picked by strobe, address, enable
// - polled full bus steps each edge
// - pll enable selects internal output timing; code also needs ctrl pll bit set, which resets to 0
// - data out when enables low, queue selected
// - address enable selects new read queue
// - almost-empty pin may mirror onto bus
// - new queue data on second cycle
// - top bits match id, low two quadrant
// - flag mode at reset: high polled
// - master select at reset: high master
module multiqueue_read_port_flag_bus (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration pins
  input wire logic flagModeSelect,
  input wire logic masterSelect,
  input wire logic [2:0] deviceId,
  input wire logic pllEnable,
  // read side pins
  input wire logic readEnableN,
  input wire logic outputEnableN,
  input wire logic readAddrEnable,
  input wire logic [7:0] readAddrBus,
  input wire logic emptyFlagStrobe,
  // write side pins
  input wire logic writeAddrEnable,
  input wire logic [7:0] writeAddrBus,
  input wire logic fullFlagStrobe,
  // queue levels from the core
  input wire logic [31:0] queueAlmostEmpty,
  input wire logic [31:0] queueAlmostFull,
  // head word load from the core
  input wire logic headWrEn,
  input wire logic [4:0] headWrQueue,
  input wire logic [39:0] headWrData,
  // data output
  output logic [39:0] dataOut,
  output logic dataOutEn,
  // flag pins
  output logic almostEmptyFlagN,
  output logic almostEmptyFlagEn,
  output logic almostFullFlagN,
  output logic almostFullFlagEn,
  output logic [7:0] almostEmptyStatusBus,
  output logic almostEmptyStatusEn,
  output logic [7:0] almostFullStatusBus,
  output logic almostFullStatusEn,
  output logic emptyFlagSync,
  output logic fullFlagSync,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // two flop synchronisers for pins, first stage read only by second
  logic [27:0] pinMeta_r; // first stage
  logic [27:0] pinSync_r; // second stage
  logic [27:0] pinRaw; // packed pin inputs
  assign pinRaw = {flagModeSelect, masterSelect, deviceId, pllEnable, readEnableN,
                   outputEnableN, readAddrEnable, readAddrBus, emptyFlagStrobe,
                   writeAddrEnable, writeAddrBus, fullFlagStrobe};
  always_ff @(posedge clk) begin
    pinMeta_r <= pinRaw;
    pinSync_r <= pinMeta_r;
  end
  // synced pin names
  wire fmS = pinSync_r[27];
  wire mastS = pinSync_r[26];
  wire [2:0] idS = pinSync_r[25:23];
  wire pllS = pinSync_r[22];
  wire renS = pinSync_r[21];
  wire oenS = pinSync_r[20];
  wire radenS = pinSync_r[19];
  wire [7:0] rdAddrS = pinSync_r[18:11];
  wire estrS = pinSync_r[10];
  wire wadenS = pinSync_r[9];
  wire [7:0] wrAddrS = pinSync_r[8:1];
  wire fstrS = pinSync_r[0];

  // straps caught while reset is held, so the value seen at release is kept
  logic polled_r; // polled flag bus mode
  logic master_r; // master role
  logic [2:0] id_r; // device identity
  always_ff @(posedge clk) begin
    if (reset) begin
      polled_r <= fmS;
      master_r <= mastS;
      id_r <= idS;
    end
  end

  // register bus state
  logic [31:0] ctrl_r; // pll gate and mirror lane
  logic awHeld_r, wHeld_r; // captured halves of a write
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  wire pllCtl = ctrl_r[`MQ_CTRL_PLL_BIT];
  wire mirrorOn = ctrl_r[`MQ_CTRL_MIRROR_BIT];
  wire [2:0] mirrorLane = ctrl_r[`MQ_CTRL_MIRROR_LSB +: 3];

  // read address decode: top bits match identity
  wire rdIdHit = (rdAddrS[7:5] == id_r);
  wire wrIdHit = (wrAddrS[7:5] == id_r);
  wire rdSelect = radenS & rdIdHit;
  wire rdDeselect = radenS & ~rdIdHit;
  wire [1:0] rdQuad = rdAddrS[1:0];
  wire [1:0] wrQuad = wrAddrS[1:0];

  // read queue selection state
  logic [4:0] rdQueue_r; // selected read queue
  logic rdSelected_r; // this device owns the read port
  logic everSelected_r; // slave has been selected once
  logic switchPipe_r; // queue change, seen one cycle late
  always_ff @(posedge clk) begin
    if (reset) begin
      rdQueue_r <= 5'h00;
      rdSelected_r <= 1'b0;
      everSelected_r <= 1'b0;
      switchPipe_r <= 1'b0;
    end else begin
      switchPipe_r <= rdSelect;
      if (rdSelect) begin
        rdQueue_r <= rdAddrS[4:0];
        rdSelected_r <= 1'b1;
        everSelected_r <= 1'b1;
      end else if (rdDeselect) begin
        rdSelected_r <= 1'b0;
      end
    end
  end

  // write queue selection for the full flag
  logic [4:0] wrQueue_r; // selected write queue
  logic wrSelected_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      wrQueue_r <= 5'h00;
      wrSelected_r <= 1'b0;
    end else if (wadenS & ~fstrS) begin
      wrQueue_r <= wrAddrS[4:0];
      wrSelected_r <= wrIdHit;
    end
  end

  // head word memory
  queue_mem_if memBus ();
  queue_head_mem headMem (
    .clk(clk),
    .mp(memBus.mem)
  );
  // read when enabled, or on the second cycle of a queue switch
  wire readFire = rdSelected_r & ~renS & ~oenS;
  wire switchLoad = switchPipe_r;
  assign memBus.rdAddr = rdQueue_r;
  assign memBus.rdEn = readFire | switchLoad;
  assign memBus.wrAddr = headWrQueue;
  assign memBus.wrEn = headWrEn;
  assign memBus.wrData = headWrData;

  // output enable of the data bus
  wire driveAllowed = master_r | everSelected_r;
  wire dataEnNxt = driveAllowed & ~oenS;
  // pll path: with pll on, data are taken one stage later off the memory register
  logic [39:0] pllStage_r;
  wire usePll = pllS & pllCtl;
  logic dataValid_r;
  logic pllValid_r; // valid one stage later, else the pll path shows stale data
  always_ff @(posedge clk) begin
    if (reset) begin
      dataOut <= 40'h00_0000_0000;
      dataOutEn <= 1'b0;
      pllStage_r <= 40'h00_0000_0000;
      dataValid_r <= 1'b0;
      pllValid_r <= 1'b0;
    end else begin
      dataOutEn <= dataEnNxt;
      dataValid_r <= memBus.rdEn;
      pllValid_r <= dataValid_r;
      pllStage_r <= memBus.rdData;
      if (usePll ? pllValid_r : dataValid_r) begin
        dataOut <= usePll ? pllStage_r : memBus.rdData;
      end
    end
  end

  // polled quadrant sequencers, gray along the path
  mq_read_port_pkg::quad_e eQuad_r, eQuad_nxt, fQuad_r, fQuad_nxt;
  always_comb begin
    case (eQuad_r)
      mq_read_port_pkg::QUAD0: eQuad_nxt = mq_read_port_pkg::QUAD1;
      mq_read_port_pkg::QUAD1: eQuad_nxt = mq_read_port_pkg::QUAD2;
      mq_read_port_pkg::QUAD2: eQuad_nxt = mq_read_port_pkg::QUAD3;
      mq_read_port_pkg::QUAD3: eQuad_nxt = mq_read_port_pkg::QUAD0;
      default: eQuad_nxt = mq_read_port_pkg::QUAD0;
    endcase
    case (fQuad_r)
      mq_read_port_pkg::QUAD0: fQuad_nxt = mq_read_port_pkg::QUAD1;
      mq_read_port_pkg::QUAD1: fQuad_nxt = mq_read_port_pkg::QUAD2;
      mq_read_port_pkg::QUAD2: fQuad_nxt = mq_read_port_pkg::QUAD3;
      mq_read_port_pkg::QUAD3: fQuad_nxt = mq_read_port_pkg::QUAD0;
      default: fQuad_nxt = mq_read_port_pkg::QUAD0;
    endcase
  end

  // direct quadrant latches; empty strobe with address enable is ignored, full strobe needs it
  logic [1:0] eDirQuad_r, fDirQuad_r;
  logic eOwn_r, fOwn_r; // this device owns the status bus
  wire eStrobeTake = estrS & ~radenS;
  wire fStrobeTake = fstrS & wadenS;
  always_ff @(posedge clk) begin
    if (reset) begin
      eQuad_r <= mq_read_port_pkg::QUAD0;
      fQuad_r <= mq_read_port_pkg::QUAD0;
      eDirQuad_r <= 2'h0;
      fDirQuad_r <= 2'h0;
      eOwn_r <= 1'b0;
      fOwn_r <= 1'b0;
    end else begin
      eQuad_r <= eQuad_nxt;
      fQuad_r <= fQuad_nxt;
      if (eStrobeTake) begin
        eDirQuad_r <= rdQuad;
        eOwn_r <= rdIdHit;
      end
      if (fStrobeTake) begin
        fDirQuad_r <= wrQuad;
        fOwn_r <= wrIdHit;
      end
    end
  end

  // quadrant index into the queue vectors, gray state decoded to binary
  wire [1:0] ePollBin = {eQuad_r[1], eQuad_r[1] ^ eQuad_r[0]};
  wire [1:0] fPollBin = {fQuad_r[1], fQuad_r[1] ^ fQuad_r[0]};
  wire [1:0] eQuadSel = polled_r ? ePollBin : eDirQuad_r;
  wire [1:0] fQuadSel = polled_r ? fPollBin : fDirQuad_r;
  wire [7:0] eQuadBits = queueAlmostEmpty[{eQuadSel, 3'h0} +: 8];
  wire [7:0] fQuadBits = queueAlmostFull[{fQuadSel, 3'h0} +: 8];
  wire aeNow = queueAlmostEmpty[rdQueue_r];
  wire afNow = queueAlmostFull[wrQueue_r];

  // active low status lanes with optional mirror of the single flag
  logic [7:0] eLaneNxt;
  genvar lane;
  generate
    for (lane = 0; lane < 8; lane++) begin : g_lane
      assign eLaneNxt[lane] = (mirrorOn && mirrorLane == 3'(lane)) ? ~aeNow
                              : ~eQuadBits[lane];
    end
  endgenerate

  // flag outputs, the bus floats when this device does not own it
  wire busRole = master_r | everSelected_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      almostEmptyFlagN <= 1'b1;
      almostEmptyFlagEn <= 1'b0;
      almostFullFlagN <= 1'b1;
      almostFullFlagEn <= 1'b0;
      almostEmptyStatusBus <= 8'hff;
      almostEmptyStatusEn <= 1'b0;
      almostFullStatusBus <= 8'hff;
      almostFullStatusEn <= 1'b0;
      emptyFlagSync <= 1'b0;
      fullFlagSync <= 1'b0;
    end else begin
      almostEmptyFlagN <= ~aeNow;
      almostEmptyFlagEn <= rdSelected_r;
      almostFullFlagN <= ~afNow;
      almostFullFlagEn <= wrSelected_r;
      almostEmptyStatusBus <= eLaneNxt;
      almostEmptyStatusEn <= polled_r ? busRole : eOwn_r;
      almostFullStatusBus <= ~fQuadBits;
      almostFullStatusEn <= polled_r ? busRole : fOwn_r;
      emptyFlagSync <= polled_r & (eQuadSel == 2'h0);
      fullFlagSync <= polled_r & (fQuadSel == 2'h0);
    end
  end

  // axi4-lite write: address and data in either order, response after both
  wire wrGo = awHeld_r & wHeld_r & ~bvalid;
  wire wrCtrlHit = (awAddr_r == `MQ_OFF_CTRL);
  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `MQ_AXI_OKAY;
      ctrl_r <= `MQ_CTRL_RESET;
    end else begin
      awready <= ~awHeld_r & ~awready & awvalid;
      wready <= ~wHeld_r & ~wready & wvalid;
      if (awready & awvalid) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wready & wvalid) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (wrGo) begin
        bvalid <= 1'b1;
        bresp <= wrCtrlHit ? `MQ_AXI_OKAY : `MQ_AXI_SLVERR;
        if (wrCtrlHit & wStrb_r[0]) begin
          ctrl_r <= {27'h000_0000, wData_r[4:0]};
        end
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
    end
  end

  // axi4-lite read: one cycle to accept, data next cycle
  logic [31:0] rdMux;
  logic rdHit;
  always_comb begin
    rdHit = 1'b1;
    case (araddr)
      `MQ_OFF_CTRL: rdMux = ctrl_r;
      `MQ_OFF_STAT: rdMux = {20'h0_0000, id_r, master_r, polled_r, everSelected_r,
                             rdSelected_r, rdQueue_r[4:0]};
      `MQ_OFF_QSTAT: rdMux = {queueAlmostFull[15:0] & 16'hffff, queueAlmostEmpty[15:0]};
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `MQ_AXI_OKAY;
    end else begin
      arready <= ~arready & ~rvalid & arvalid;
      if (arready & arvalid) begin
        rvalid <= 1'b1;
        rdata <= rdMux;
        rresp <= rdHit ? `MQ_AXI_OKAY : `MQ_AXI_SLVERR;
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // multiqueue_read_port_flag_bus
`default_nettype wire

// *** dv/multiqueue_read_port_checker.sv ***
// Purpose: port-level checks for the multi-queue read port and flag buses
// Assumes: straps change only while reset is high
// Notes: latencies include the two-flop pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module multiqueue_read_port_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins watched
  input wire logic flagModeSelect,
  input wire logic masterSelect,
  input wire logic [2:0] deviceId,
  input wire logic readEnableN,
  input wire logic outputEnableN,
  input wire logic readAddrEnable,
  input wire logic [7:0] readAddrBus,
  // outputs watched
  input wire logic [39:0] dataOut,
  input wire logic dataOutEn,
  input wire logic almostEmptyFlagN,
  input wire logic almostFullFlagN,
  input wire logic emptyFlagSync,
  input wire logic fullFlagSync
);
  logic [3:0] relCnt_r; // edges since reset release, saturating
  logic [3:0] idleCnt_r; // cycles with no read and no select
  logic everSel_r; // own id seen on a select; early, so the slave check stays safe
  // helpers cleared by reset so nothing leaks across a second reset
  always_ff @(posedge clk) begin
    if (reset) begin
      relCnt_r <= 4'h0;
      idleCnt_r <= 4'h0;
      everSel_r <= 1'b0;
    end else begin
      relCnt_r <= (relCnt_r == 4'hf) ? relCnt_r : relCnt_r + 4'h1;
      idleCnt_r <= (!readEnableN || readAddrEnable) ? 4'h0 :
                   (idleCnt_r == 4'hf) ? idleCnt_r : idleCnt_r + 4'h1;
      everSel_r <= everSel_r | (readAddrEnable && readAddrBus[7:5] == deviceId);
    end
  end
  AST_OE_HIGH_FLOATS: assert property (@(posedge clk) disable iff (reset)
    outputEnableN && $past(outputEnableN, 1) && $past(outputEnableN, 2) && $past(outputEnableN, 3)
    |-> !dataOutEn) else $error("data bus driven while output enable high");
  AST_MASTER_DRIVES: assert property (@(posedge clk) disable iff (reset)
    relCnt_r > 4'h4 && masterSelect && !outputEnableN && !$past(outputEnableN, 1)
    && !$past(outputEnableN, 2) && !$past(outputEnableN, 3) |-> dataOutEn)
    else $error("master not driving data bus");
  AST_SLAVE_FLOATS: assert property (@(posedge clk) disable iff (reset)
    relCnt_r > 4'h2 && !masterSelect && !everSel_r |-> !dataOutEn)
    else $error("unselected slave drives data bus");
  AST_DATA_HOLDS: assert property (@(posedge clk) disable iff (reset)
    idleCnt_r > 4'h8 |-> $stable(dataOut)) else $error("data changed without a read");
  AST_EMPTY_POLL_CYCLE: assert property (@(posedge clk) disable iff (reset)
    emptyFlagSync |=> !emptyFlagSync [*3] ##1 emptyFlagSync)
    else $error("empty sync period not four");
  AST_FULL_POLL_CYCLE: assert property (@(posedge clk) disable iff (reset)
    $rose(fullFlagSync) |-> ##4 $rose(fullFlagSync)) else $error("full sync period not four");
  AST_DIRECT_QUIET: assert property (@(posedge clk) disable iff (reset)
    relCnt_r > 4'h2 && !flagModeSelect |-> !emptyFlagSync && !fullFlagSync)
    else $error("sync pulse in direct mode");
  AST_RESET_IDLE: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> almostEmptyFlagN && almostFullFlagN && !dataOutEn)
    else $error("outputs active straight after reset");
endmodule // multiqueue_read_port_checker
bind multiqueue_read_port_flag_bus multiqueue_read_port_checker i_chk (.clk(clk), .reset(reset),
  .flagModeSelect(flagModeSelect), .masterSelect(masterSelect), .deviceId(deviceId),
  .readEnableN(readEnableN), .outputEnableN(outputEnableN), .readAddrEnable(readAddrEnable),
  .readAddrBus(readAddrBus), .dataOut(dataOut), .dataOutEn(dataOutEn),
  .almostEmptyFlagN(almostEmptyFlagN), .almostFullFlagN(almostFullFlagN),
  .emptyFlagSync(emptyFlagSync), .fullFlagSync(fullFlagSync));
`default_nettype wire

// *** dv/host_line_model.sv ***
// Purpose: host view of the three-state data lines
// Assumes: no pull resistor on the lines
// Notes: a released bus shows the inverse of its last value, never a kind guess
`timescale 1ns/1ps
`default_nettype none
module host_line_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [39:0] dataOut,
  input wire logic dataOutEn,
  // host side
  output logic [39:0] dataLine
);
  logic [39:0] last_r; // last value the device drove
  // undriven lines drift away from the last value
  assign dataLine = dataOutEn ? dataOut : ~last_r;
  // remember what was on the lines
  always_ff @(posedge clk) begin
    if (dataOutEn) begin
      last_r <= dataOut;
    end
  end
endmodule // host_line_model
`default_nettype wire

// *** dv/multiqueue_read_port_flag_bus_bench.sv ***
// Purpose: directed bench for the read port and flag buses
// Assumes: pins driven at rising edges, outputs sampled at falling edges
// Notes: waits cover the two-flop pin synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "mq_read_port_cfg.svh"
module multiqueue_read_port_flag_bus_bench;
  localparam logic [2:0] ID = 3'h2; // device number, arbitrary
  localparam logic [31:0] AE = 32'h8142_3c0f; // one distinct byte per quadrant
  localparam logic [31:0] AF = 32'h0f3c_4281;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic flagModeSelect = 1'b0, masterSelect = 1'b1, pllEnable = 1'b0, headWrEn = 1'b0;
  logic readEnableN = 1'b1, outputEnableN = 1'b0, readAddrEnable = 1'b0, emptyFlagStrobe = 1'b0;
  logic writeAddrEnable = 1'b0, fullFlagStrobe = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] readAddrBus = 8'h00, writeAddrBus = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] queueAlmostEmpty = AE, queueAlmostFull = AF, wdata = 32'h0, rdata;
  logic [4:0] headWrQueue = 5'h00;
  logic [3:0] wstrb = 4'hf;
  logic [39:0] headWrData = 40'h0, dataOut, dataLine;
  logic dataOutEn, almostEmptyFlagN, almostEmptyFlagEn, almostFullFlagN, almostFullFlagEn;
  logic [7:0] almostEmptyStatusBus, almostFullStatusBus;
  logic almostEmptyStatusEn, almostFullStatusEn, emptyFlagSync, fullFlagSync;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int miscompares = 0, check_count = 0, cyc = 0;
  logic [4:0] qs [3] = '{5'd3, 5'd4, 5'd17}; // queues visited
  // 40 MHz clock
  always #12.5 clk = ~clk;
  multiqueue_read_port_flag_bus i_dut (.clk(clk), .reset(reset),
    .flagModeSelect(flagModeSelect), .masterSelect(masterSelect), .deviceId(ID),
    .pllEnable(pllEnable), .readEnableN(readEnableN), .outputEnableN(outputEnableN),
    .readAddrEnable(readAddrEnable), .readAddrBus(readAddrBus), .emptyFlagStrobe(emptyFlagStrobe),
    .writeAddrEnable(writeAddrEnable), .writeAddrBus(writeAddrBus),
    .fullFlagStrobe(fullFlagStrobe), .queueAlmostEmpty(queueAlmostEmpty),
    .queueAlmostFull(queueAlmostFull), .headWrEn(headWrEn), .headWrQueue(headWrQueue),
    .headWrData(headWrData), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .almostEmptyFlagN(almostEmptyFlagN), .almostEmptyFlagEn(almostEmptyFlagEn),
    .almostFullFlagN(almostFullFlagN), .almostFullFlagEn(almostFullFlagEn),
    .almostEmptyStatusBus(almostEmptyStatusBus), .almostEmptyStatusEn(almostEmptyStatusEn),
    .almostFullStatusBus(almostFullStatusBus), .almostFullStatusEn(almostFullStatusEn),
    .emptyFlagSync(emptyFlagSync), .fullFlagSync(fullFlagSync), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  host_line_model i_host (.clk(clk), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .dataLine(dataLine));
  // head word of a queue, distinct per queue
  function automatic logic [39:0] wd(input logic [4:0] q);
    return {q, 3'b101, 24'h5ac3e1, 3'b000, q};
  endfunction
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // straps are only moved while reset is held
  task automatic rst(input logic fm, input logic m);
    @(posedge clk);
    reset <= 1'b1;
    flagModeSelect <= fm;
    masterSelect <= m;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
  endtask
  // one-cycle select pulse, never together with a strobe
  task automatic sel(input logic [2:0] id, input logic [4:0] q);
    @(posedge clk);
    readAddrBus <= {id, q};
    readAddrEnable <= 1'b1;
    @(posedge clk);
    readAddrEnable <= 1'b0;
  endtask
  // bit 4 set on purpose: it must be ignored for quadrants
  task automatic empty_flag_strobe(input logic [1:0] q);
    @(posedge clk);
    readAddrBus <= {ID, 3'b100, q};
    emptyFlagStrobe <= 1'b1;
    @(posedge clk);
    emptyFlagStrobe <= 1'b0;
  endtask
  task automatic wq(input logic [4:0] a, input logic s);
    @(posedge clk);
    writeAddrBus <= {ID, a};
    writeAddrEnable <= 1'b1;
    fullFlagStrobe <= s;
    @(posedge clk);
    writeAddrEnable <= 1'b0;
    fullFlagStrobe <= 1'b0;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", ed, rdata);
  endtask
  // walk four polled quadrants starting at the sync pulse
  task automatic poll(input logic [31:0] p, input logic f);
    int k;
    k = 0;
    while ((f ? fullFlagSync : emptyFlagSync) !== 1'b1 && k < 8) begin
      wt(1);
      k++;
    end
    chk("sync", 1'b1, f ? fullFlagSync : emptyFlagSync);
    for (k = 0; k < 4; k++) begin
      chk("pollBus", 8'(~p[k*8+:8]), f ? almostFullStatusBus : almostEmptyStatusBus);
      wt(1);
    end
  endtask
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      $display("Error cycles expected below 5000 seen %0d", cyc);
      end_of_test();
    end
  end
  initial begin
    rst(1'b0, 1'b1);
    wt(1);
    chk("aeFlag", 1'b1, almostEmptyFlagN);
    chk("dataOutEn", 1'b0, dataOutEn);
    axr(`MQ_OFF_CTRL, `MQ_AXI_OKAY, `MQ_CTRL_RESET);
    axr(8'h10, `MQ_AXI_SLVERR, 32'h0);
    axw(8'h10, 32'hffff_ffff, `MQ_AXI_SLVERR);
    for (int q = 0; q < 32; q++) begin
      @(posedge clk);
      headWrEn <= 1'b1;
      headWrQueue <= 5'(q);
      headWrData <= wd(5'(q));
    end
    @(posedge clk);
    headWrEn <= 1'b0;
    foreach (qs[i]) begin
      sel(ID, qs[i]);
      wq(qs[i], 1'b0);
      wt(8);
      chk("data", wd(qs[i]), dataLine);
      chk("aeFlag", !AE[qs[i]], almostEmptyFlagN);
      chk("afFlag", !AF[qs[i]], almostFullFlagN);
      chk("aeFlagEn", 1'b1, almostEmptyFlagEn);
      chk("afFlagEn", 1'b1, almostFullFlagEn);
    end
    // head changes while read enable is held high must not show
    @(posedge clk);
    headWrEn <= 1'b1;
    headWrQueue <= 5'd17;
    headWrData <= ~wd(5'd17);
    @(posedge clk);
    headWrEn <= 1'b0;
    wt(8);
    chk("data", wd(5'd17), dataLine);
    @(posedge clk);
    readEnableN <= 1'b0;
    wt(8);
    chk("data", ~wd(5'd17), dataLine);
    @(posedge clk);
    readEnableN <= 1'b1;
    outputEnableN <= 1'b1;
    wt(6);
    chk("dataOutEn", 1'b0, dataOutEn);
    @(posedge clk);
    outputEnableN <= 1'b0;
    wt(6);
    chk("dataOutEn", 1'b1, dataOutEn);
    for (int q = 0; q < 4; q++) begin
      empty_flag_strobe(2'(q));
      wq({3'b100, 2'(q)}, 1'b1);
      wt(6);
      chk("aeBus", 8'(~AE[q*8+:8]), almostEmptyStatusBus);
      chk("afBus", 8'(~AF[q*8+:8]), almostFullStatusBus);
      chk("aeBusEn", 1'b1, almostEmptyStatusEn);
      chk("afBusEn", 1'b1, almostFullStatusEn);
    end
    axw(`MQ_OFF_CTRL, 32'h6, `MQ_AXI_OKAY);
    wt(2);
    chk("aeBus", 8'h7c, almostEmptyStatusBus);
    axw(`MQ_OFF_CTRL, 32'h1, `MQ_AXI_OKAY);
    @(posedge clk);
    pllEnable <= 1'b1;
    axr(`MQ_OFF_CTRL, `MQ_AXI_OKAY, 32'h1);
    sel(ID, 5'd6);
    wt(10);
    chk("data", wd(5'd6), dataLine);
    rst(1'b1, 1'b1);
    poll(AE, 1'b0);
    poll(AF, 1'b1);
    rst(1'b0, 1'b0);
    wt(6);
    chk("aeBusEn", 1'b0, almostEmptyStatusEn);
    chk("dataOutEn", 1'b0, dataOutEn);
    sel(3'h5, 5'd2);
    wt(8);
    chk("dataOutEn", 1'b0, dataOutEn);
    sel(ID, 5'd2);
    wt(8);
    chk("dataOutEn", 1'b1, dataOutEn);
    chk("data", wd(5'd2), dataLine);
    axr(`MQ_OFF_STAT, `MQ_AXI_OKAY, 32'h0000_0462);
    end_of_test();
  end
endmodule // multiqueue_read_port_flag_bus_bench
`default_nettype wire
